// ### design/xm_ext_mem_if.sv
// external parallel memory interface: multiplexed address/data bus with wait states
`timescale 1ns/100ps
`default_nettype none
`include "xm_params.svh"
// Function
// - low address and data share one bus; high address width is configurable
// - when enabled, interface pin control overrides port direction settings
// - address alone decides internal or external; strobes only for external
// - low address is valid on the shared bus when latch strobe falls
// - latch strobe stays low through the data phase
// - internal accesses may show address and latch activity, never read/write strobes
// - when disabled, shared pins follow their port and direction settings
// - when disabled, addresses above internal memory never alias into it
// - pull-ups on shared bus follow port output bits set to one
// - bus keeper holds last level whenever the shared bus would float
// - four wait-state settings, one of them with no wait
// - external space splits into two sectors with own wait settings
// - each sector's wait pair applies only to its own accesses
// - trailing latch pulse in T4, or T5 with one wait, if next uses RAM
// - trailing latch pulse in T6 for two waits, T7 with address delay
// - wait codes: none, one, two, two plus one cycle before next address
// - three-bit limit splits sectors in 8 KB steps; zero means one upper sector
// - enable bit hands pins over; keeper enable acts regardless of it
module xm_ext_mem_if
	import xm_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic req_i, // access request
	input wire logic we_i, // 1 write, 0 read
	input wire logic [15:0] addr_i, // data-space address
	input wire logic [7:0] wdata_i, // write data
	input wire logic next_ram_i, // next instruction accesses RAM
	output logic ready_o, // request may be taken
	output logic ack_o, // access done, one cycle
	output logic [7:0] rdata_o, // read data
	output logic int_sel_o, // access targets internal memory
	input wire logic ext_if_enable_i, // interface enable
	input wire logic [2:0] sector_limit_i, // sector split
	input wire logic [1:0] upper_wait_i, // upper sector wait code
	input wire logic [1:0] lower_wait_i, // lower sector wait code
	input wire logic bus_keeper_enable_i, // keeper on shared bus
	input wire logic [2:0] high_addr_mask_i, // high address width code
	input wire logic [7:0] lo_port_out_i, // shared-bus port output register
	input wire logic [7:0] lo_port_dir_i, // shared-bus port direction register
	input wire logic [7:0] hi_port_out_i, // high-bus port output register
	input wire logic [7:0] hi_port_dir_i, // high-bus port direction register
	input wire logic [7:0] muxed_low_addr_data_bus_i, // shared bus level
	output logic [7:0] muxed_low_addr_data_bus_o, // shared bus drive value
	output logic [7:0] muxed_low_addr_data_bus_oe_o, // shared bus drive enable
	output logic [7:0] lo_pullup_o, // pull-up enables on shared bus
	output logic lo_keeper_en_o, // keeper active
	output logic [7:0] lo_keeper_o, // level held by keeper
	output logic [7:0] high_addr_bus_o, // high address / port value
	output logic [7:0] high_addr_bus_oe_o, // high bus drive enable
	output logic ale_o, // address latch strobe, active high
	output logic rd_b_o, // read strobe, active low
	output logic wr_b_o // write strobe, active low
);
	// sector split and per-sector wait selection
	function automatic logic [1:0] sector_wait(input logic [15:0] a, input logic [2:0] lim,
		input logic [1:0] up, input logic [1:0] lo);
		logic [15:0] bound;
		bound = 16'({13'h0, lim} * `XM_SECTOR_STEP);
		// lower pair only below the boundary
		if (lim == 3'h0 || a >= bound) begin
			sector_wait = up;
		end else begin
			sector_wait = lo;
		end
	endfunction : sector_wait

	// high pins used, released from the top
	function automatic logic [7:0] hi_used(input logic [2:0] m);
		logic [3:0] n;
		n = (m == `XM_MASK_NONE) ? 4'h0 : 4'(`XM_HI_FULL - {1'b0, m});
		hi_used = 8'((9'h001 << n) - 9'h001);
	endfunction : hi_used

	xm_state_type state_q, state_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] wd_q, wd_d, rdata_q, rdata_d, keep_q, keep_d;
	logic we_q, we_d, ext_q, ext_d, nxt_q, nxt_d, ack_q, ack_d;
	logic [1:0] ws_q, ws_d, cnt_q, cnt_d;
	logic int_hit, bus_drive;
	logic [7:0] bus_val;

	// internal or external from the address only
	assign int_hit = addr_i <= `XM_INT_TOP;
	assign int_sel_o = int_hit;
	assign ready_o = state_q == XM_IDLE;
	assign ack_o = ack_q;
	assign rdata_o = rdata_q;

	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		wd_d = wd_q;
		we_d = we_q;
		ext_d = ext_q;
		nxt_d = nxt_q;
		ws_d = ws_q;
		cnt_d = cnt_q;
		rdata_d = rdata_q;
		ack_d = 1'b0;
		unique case (state_q)
			XM_IDLE: begin
				if (req_i) begin
					if (ext_if_enable_i) begin
						state_d = XM_ADDR;
						addr_d = addr_i;
						wd_d = wdata_i;
						we_d = we_i;
						ext_d = ~int_hit;
						nxt_d = next_ram_i;
						ws_d = sector_wait(addr_i, sector_limit_i, upper_wait_i, lower_wait_i);
					end else begin
						// no alias: disabled external reads return zero
						ack_d = 1'b1;
						if (!int_hit && !we_i) begin
							rdata_d = `XM_RST_BYTE;
						end
					end
				end
			end
			XM_ADDR: begin
				if (ext_q) begin
					state_d = XM_STRB;
					cnt_d = (ws_q == `XM_WS_NONE) ? 2'h0 : (ws_q == `XM_WS_ONE) ? 2'h1 : 2'h2;
				end else begin
					state_d = XM_IDLE;
					ack_d = 1'b1;
				end
			end
			XM_STRB: begin
				if (cnt_q == 2'h0) begin
					state_d = XM_HOLD;
					// read data taken as the strobe ends
					if (!we_q) begin
						rdata_d = muxed_low_addr_data_bus_i;
					end
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			XM_HOLD: begin
				ack_d = 1'b1;
				// extra cycle before next address delays the trailing pulse
				if (ws_q == `XM_WS_TWO_GAP) begin
					state_d = XM_GAP;
				end else begin
					state_d = nxt_q ? XM_ALE : XM_IDLE;
				end
			end
			XM_GAP: begin
				state_d = nxt_q ? XM_ALE : XM_IDLE;
			end
			XM_ALE: begin
				state_d = XM_IDLE;
			end
			default: begin
				state_d = XM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q <= XM_IDLE;
			addr_q <= `XM_RST_ADDR;
			wd_q <= `XM_RST_BYTE;
			we_q <= 1'b0;
			ext_q <= 1'b0;
			nxt_q <= 1'b0;
			ws_q <= `XM_WS_NONE;
			cnt_q <= `XM_RST_CNT;
			rdata_q <= `XM_RST_BYTE;
			ack_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			we_q <= we_d;
			ext_q <= ext_d;
			nxt_q <= nxt_d;
			ws_q <= ws_d;
			cnt_q <= cnt_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// address out while latch strobe is high, so it is valid as it falls
	// trailing pulse state reached only when next access uses RAM
	always_comb begin
		bus_drive = 1'b0;
		bus_val = addr_q[7:0];
		unique case (state_q)
			XM_ADDR, XM_ALE: begin
				bus_drive = 1'b1;
			end
			XM_STRB, XM_HOLD: begin
				// data byte on the same lines after the address phase
				bus_drive = we_q;
				bus_val = wd_q;
			end
			XM_IDLE, XM_GAP: begin
				bus_drive = 1'b0;
			end
			default: begin
				bus_drive = 1'b0;
			end
		endcase
	end

	// latch strobe high only in address and trailing pulse states
	assign ale_o = ext_if_enable_i && (state_q == XM_ADDR || state_q == XM_ALE);
	// strobes only toggle for external accesses
	assign rd_b_o = !(ext_q && !we_q && state_q == XM_STRB);
	assign wr_b_o = !(ext_q && we_q && state_q == XM_STRB);

	// interface owns the pins while enabled
	// otherwise the port registers govern them
	always_comb begin
		if (ext_if_enable_i) begin
			muxed_low_addr_data_bus_o = bus_val;
			muxed_low_addr_data_bus_oe_o = {8{bus_drive}};
		end else begin
			muxed_low_addr_data_bus_o = lo_port_out_i;
			muxed_low_addr_data_bus_oe_o = lo_port_dir_i;
		end
	end

	// masked high pins go back to the port
	always_comb begin
		logic [7:0] used;
		used = ext_if_enable_i ? hi_used(high_addr_mask_i) : 8'h00;
		high_addr_bus_o = (addr_q[15:8] & used) | (hi_port_out_i & ~used);
		high_addr_bus_oe_o = used | (hi_port_dir_i & ~used);
	end

	// pull-ups follow the port output bits on undriven lines
	assign lo_pullup_o = lo_port_out_i & ~muxed_low_addr_data_bus_oe_o;

	// keeper remembers the last level seen on the lines
	// keeper enable is independent of the interface enable
	assign keep_d = muxed_low_addr_data_bus_i;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			keep_q <= `XM_RST_BYTE;
		end else begin
			keep_q <= keep_d;
		end
	end
	assign lo_keeper_en_o = bus_keeper_enable_i;
	assign lo_keeper_o = keep_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_addr_ph;
		ale_o && state_q == XM_ADDR && ext_q;
	endsequence
	sequence s_strobe_ph;
		!ale_o && (!rd_b_o || !wr_b_o);
	endsequence

	a_addr_then_strobe: assert property (s_addr_ph |=> s_strobe_ph)
		else $error("strobe did not follow address phase");
	a_addr_on_bus: assert property (ale_o |-> muxed_low_addr_data_bus_o == addr_q[7:0] && muxed_low_addr_data_bus_oe_o == 8'hFF)
		else $error("low address not driven while latch strobe high");
	a_ale_low_strobe: assert property (!rd_b_o || !wr_b_o |-> !ale_o)
		else $error("latch strobe high during data phase");
	a_int_no_strobe: assert property (state_q == XM_ADDR && !ext_q |=> rd_b_o && wr_b_o)
		else $error("strobe on internal access");
	a_zero_wait_len: assert property ((s_addr_ph and ws_q == 2'h0) |=> s_strobe_ph ##1 rd_b_o && wr_b_o)
		else $error("zero-wait strobe not one cycle");
	a_two_wait_len: assert property ((s_addr_ph and ws_q[1]) |=> s_strobe_ph [*3] ##1 rd_b_o && wr_b_o)
		else $error("two-wait strobe not three cycles");
	a_trail_t4: assert property ((s_addr_ph and (ws_q == 2'h0 && nxt_q)) |-> ##3 ale_o)
		else $error("trailing pulse missing in T4");
	a_trail_t7: assert property ((s_addr_ph and (ws_q == 2'h3 && nxt_q)) |-> ##6 ale_o)
		else $error("trailing pulse missing in T7");
	a_disabled_pins: assert property (!ext_if_enable_i |-> muxed_low_addr_data_bus_oe_o == lo_port_dir_i)
		else $error("pins not returned to port");
	a_write_drive: assert property (!wr_b_o && ext_if_enable_i |-> muxed_low_addr_data_bus_o == wd_q && muxed_low_addr_data_bus_oe_o == 8'hFF)
		else $error("write data not driven");
	a_mask_none: assert property (ext_if_enable_i && high_addr_mask_i == 3'h7 |-> high_addr_bus_oe_o == hi_port_dir_i)
		else $error("high pins not released");
endmodule : xm_ext_mem_if
`default_nettype wire

// ### design/xm_params.svh
// constants for the external parallel memory interface
`ifndef XM_PARAMS_SVH
`define XM_PARAMS_SVH
// last byte address that belongs to internal memory (arbitrary default)
`define XM_INT_TOP 16'h10FF
// sector limit step, 8 KB
`define XM_SECTOR_STEP 16'h2000
// high-address mask code that releases every high pin
`define XM_MASK_NONE 3'h7
// full width of the high address bus
`define XM_HI_FULL 4'h8
// wait-state codes
`define XM_WS_NONE 2'h0
`define XM_WS_ONE 2'h1
`define XM_WS_TWO 2'h2
`define XM_WS_TWO_GAP 2'h3
// reset values
`define XM_RST_BYTE 8'h00
`define XM_RST_ADDR 16'h0000
`define XM_RST_CNT 2'h0
`endif

// ### design/xm_pkg.sv
// types for the external parallel memory interface
`include "xm_params.svh"
package xm_pkg;
	typedef enum logic [2:0] {
		XM_IDLE = 3'h0,
		XM_ADDR = 3'h1,
		XM_STRB = 3'h2,
		XM_HOLD = 3'h3,
		XM_GAP = 3'h4,
		XM_ALE = 3'h5
	} xm_state_type;
endpackage : xm_pkg

// ### verif/xm_ext_mem_if_bench.sv
// self-checking bench for the external memory interface
`timescale 1ns/100ps
`default_nettype none
module xm_ext_mem_if_bench;
	logic clk_i, rst_b_i, req, we, nr, en, keep, ready, ack, int_sel, kp_en, ale, rd_b, wr_b, soe;
	logic [15:0] addr;
	logic [7:0] wd, lo_out, lo_dir, hi_out, hi_dir, bus, d_o, d_oe, pu, kp, hi_o, hi_oe, rdata, sq;
	logic [2:0] lim, mask;
	logic [1:0] upw, low;
	int n_mismatch, n_tests, lat, nale, nrd, nwr, noe;
	xm_ext_mem_if dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .we_i(we), .addr_i(addr),
		.wdata_i(wd), .next_ram_i(nr), .ready_o(ready), .ack_o(ack), .rdata_o(rdata),
		.int_sel_o(int_sel), .ext_if_enable_i(en), .sector_limit_i(lim), .upper_wait_i(upw),
		.lower_wait_i(low), .bus_keeper_enable_i(keep), .high_addr_mask_i(mask),
		.lo_port_out_i(lo_out), .lo_port_dir_i(lo_dir), .hi_port_out_i(hi_out),
		.hi_port_dir_i(hi_dir), .muxed_low_addr_data_bus_i(bus), .muxed_low_addr_data_bus_o(d_o),
		.muxed_low_addr_data_bus_oe_o(d_oe), .lo_pullup_o(pu), .lo_keeper_en_o(kp_en),
		.lo_keeper_o(kp), .high_addr_bus_o(hi_o), .high_addr_bus_oe_o(hi_oe), .ale_o(ale),
		.rd_b_o(rd_b), .wr_b_o(wr_b));
	xm_ext_sram mem (.ale_i(ale), .rd_b_i(rd_b), .wr_b_i(wr_b), .hi_i(hi_o), .bus_i(bus),
		.q_o(sq), .oe_o(soe));
	// a floating line shows the inverse of its last level unless pulled or kept
	// the short wire delay gives the address latch its hold time after the strobe falls
	assign #0.5 bus = (d_oe & d_o) | (~d_oe & (soe ? sq : (pu | (~pu & (kp_en ? kp : ~kp)))));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk
	task cfg(input logic e, input logic [2:0] l, input logic [1:0] u, input logic [1:0] w,
		input logic k, input logic [2:0] m);
		@(posedge clk_i);
		en <= e;
		lim <= l;
		upw <= u;
		low <= w;
		keep <= k;
		mask <= m;
	endtask : cfg
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic n);
		repeat (3) @(posedge clk_i);
		#1;
		chk("ready", 16'h1, {15'h0, ready});
		@(posedge clk_i);
		req <= 1'h1;
		we <= w;
		addr <= a;
		wd <= d;
		nr <= n;
		@(posedge clk_i);
		req <= 1'h0;
		{lat, nale, nrd, nwr, noe} = '0;
		forever begin
			#1;
			nale += ale;
			nrd += !rd_b;
			nwr += !wr_b;
			noe += (d_oe === 8'hFF);
			// latch strobe low in data phase
			if (ale === 1'h1 && (rd_b & wr_b) !== 1'h1) chk("ale_in_strobe", 16'h0, 16'h1);
			if (ack === 1'h1) break;
			if (lat > 20) begin
				chk("ack_timeout", 16'h1, 16'h0);
				break;
			end
			@(posedge clk_i);
			lat++;
		end
		// the gap setting puts its trailing latch pulse one cycle after the done pulse
		@(posedge clk_i);
		#1;
		nale += ale;
	endtask : acc
	task t_waits;
		for (int c = 0; c < 4; c++) begin
			cfg(1'h1, 3'h0, 2'(c), 2'h0, 1'h0, 3'h0);
			acc(1'h1, 16'h8000 + 16'(c), 8'hA5 ^ 8'(c), 1'h0);
			chk("wr_lat", 16'(3 + c - (c == 3)), 16'(lat));
			chk("wr_strobe", 16'(1 + c - (c == 3)), 16'(nwr));
			chk("ale_plain", 16'h1, 16'(nale));
			chk("pin_takeover", 16'h1, 16'(noe > 0));
			acc(1'h0, 16'h8000 + 16'(c), 8'h00, 1'h1);
			chk("rd_data", {8'h00, 8'hA5 ^ 8'(c)}, {8'h00, rdata});
			chk("rd_strobe", 16'(1 + c - (c == 3)), 16'(nrd));
			chk("ale_trail", 16'h2, 16'(nale));
		end
		$display("done waits");
	endtask : t_waits
	task t_sector;
		for (int l = 1; l < 8; l += 6) begin
			cfg(1'h1, 3'(l), 2'h3, 2'h0, 1'h0, 3'h0);
			acc(1'h1, 16'(l) * 16'h2000 - 16'h1, 8'h11, 1'h0);
			chk("lower_lat", 16'h3, 16'(lat));
			acc(1'h1, 16'(l) * 16'h2000, 8'h22, 1'h0);
			chk("upper_lat", 16'h5, 16'(lat));
		end
		$display("done sectors");
	endtask : t_sector
	task t_int;
		cfg(1'h1, 3'h0, 2'h2, 2'h0, 1'h0, 3'h0);
		acc(1'h0, 16'h0100, 8'h00, 1'h0);
		chk("int_lat", 16'h1, 16'(lat));
		chk("int_sel", 16'h1, {15'h0, int_sel});
		chk("int_strobes", 16'h0, 16'(nrd + nwr));
		$display("done internal");
	endtask : t_int
	task t_dis;
		cfg(1'h0, 3'h0, 2'h0, 2'h0, 1'h1, 3'h0);
		acc(1'h0, 16'h8000, 8'h00, 1'h0);
		chk("no_alias", 16'h0, {8'h00, rdata});
		chk("dis_strobes", 16'h0, 16'(nrd + nwr));
		chk("lo_pins", {lo_dir, lo_out}, {d_oe, d_o});
		chk("hi_pins", {hi_dir, hi_out}, {hi_oe, hi_o});
		chk("keeper_en", 16'h1, {15'h0, kp_en});
		chk("pullups", {8'h00, lo_out & ~lo_dir}, {8'h00, pu});
		$display("done disabled");
	endtask : t_dis
	task t_mask;
		logic [7:0] km;
		for (int m = 4; m < 8; m += 3) begin
			km = (m == 7) ? 8'h00 : 8'hFF >> m;
			cfg(1'h1, 3'h0, 2'h0, 2'h0, m == 7, 3'(m));
			acc(1'h1, 16'hAB40, 8'h33, 1'h0);
			chk("hi_oe", {8'h00, km | (hi_dir & ~km)}, {8'h00, hi_oe});
			chk("hi_val", {8'h00, (8'hAB & km) | (hi_out & ~km)}, {8'h00, hi_o});
			chk("keeper_en", {15'h0, m == 7}, {15'h0, kp_en});
			// released bus keeps the last written byte, with the pull-ups on top
			if (m == 7) chk("keeper_hold", {2{8'h33 | lo_out}}, {kp, bus});
		end
		$display("done mask");
	endtask : t_mask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#20000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{rst_b_i, req, we, nr, en, keep, addr, wd, lim, mask, upw, low} = '0;
		lo_out = 8'h3C;
		lo_dir = 8'h00;
		hi_out = 8'hC3;
		hi_dir = 8'h5A;
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'h1;
		t_waits();
		t_sector();
		t_int();
		t_dis();
		t_mask();
		conclude();
	end
endmodule : xm_ext_mem_if_bench
`default_nettype wire

// ### verif/xm_ext_sram.sv
// external byte memory behind an address latch, far side of the shared bus
`timescale 1ns/100ps
`default_nettype none
module xm_ext_sram (
	input wire logic ale_i, // latch strobe
	input wire logic rd_b_i, // read strobe, active low
	input wire logic wr_b_i, // write strobe, active low
	input wire logic [7:0] hi_i, // high address
	input wire logic [7:0] bus_i, // shared bus level
	output logic [7:0] q_o, // read data
	output logic oe_o // drives shared bus
);
	logic [7:0] lat;
	logic [7:0] mem [0:65535];
	// transparent while the strobe is high, holds the low address once it falls
	always_latch begin
		if (ale_i) begin
			lat <= bus_i;
		end
	end
	always @(posedge wr_b_i) begin
		mem[{hi_i, lat}] <= bus_i;
	end
	assign oe_o = !rd_b_i;
	assign q_o = mem[{hi_i, lat}];
endmodule : xm_ext_sram
`default_nettype wire
